/* src/rcatr_regs.v */
// Purpose: configuration registers and throttle alert timing of a buck-boost regulator
// Assumes: serial word protocol decoded upstream into one-cycle word strobes
// Notes: alert timing counters run at 25 MHz
//
// Overview of operation
// - word write to code 0x48 stores the system-side throttle threshold
// - only threshold bits 13:8 are kept; other bits written are dropped
// - stored threshold field is clamped to at most 110010 (12800mA)
// - threshold register resets to 0x1000
// - reading the threshold returns the stored value
// - alert asserts only after the selected debounce of sustained overcurrent
// - once asserted, alert holds at least the selected minimum duration
// - one debounce setting serves adapter-side and system-side comparisons
// - control registers are written by word at codes 0x39, 0x3c, 0x3d
// - first register bits 15:13 give forward phase comparator offset
// - first register bits 12:10 give boost phase comparator offset
// - first register bits 9:7 give reverse phase comparator offset
// - first register bits 6:5 give high-side FET short threshold
// - first register bit 2 set disables input voltage loop
// - first register bits 1 and 0 enable adapter and system discharge
// - second register bits 15,14 disable diode emulation and falling-setpoint sinking
// - second register bits 13,12 skip trim and autozero on restart
// - second register bits 11,10 enable forced reverse and audio filter, filter outside buck-boost only
// - second register bits 9:7 select switching frequency
// - second register bit 5 disables system current amp, forward without adapter
// - second register bits 4,3 enable bypass and fast reference
// - second register bit 2 stops switching, forward operation only
// - debounce codes 00..11 mean 7us, 100us, 500us, 1ms
// - duration codes mean 10,20,15,5,1ms, 500us, 100us, 0s
`timescale 1ns/1ps
`default_nettype none
`include "rcatr_regs.vh"

module rcatr_regs #(
	parameter integer CNT_W = 20
) (
	// clock and reset
	input  wire        clk_i,
	input  wire        reset_n_i,
	// register port
	input  wire        wr_i,
	input  wire        rd_i,
	input  wire [7:0]  cmd_i,
	input  wire [15:0] wdata_i,
	output reg  [15:0] rdata_o,
	output reg         rvalid_o,
	output reg         cmd_err_o,
	// operating state
	input  wire        power_good_i,
	input  wire        forward_direction_i,
	input  wire        adapter_source_i,
	input  wire        buck_boost_mode_i,
	// overcurrent comparators
	input  wire        sys_over_thr_i,
	input  wire        adapter_over_thr_i,
	output reg  [5:0]  sys_thr_code_o,
	// throttle alert
	output reg         throttle_alert_n_o,
	// first control register fields
	output reg  [2:0]  forward_phase_ofs_o,
	output reg  [2:0]  boost_phase_ofs_o,
	output reg  [2:0]  rev_phase_ofs_o,
	output reg  [1:0]  hs_short_thr_o,
	output reg         vin_loop_dis_o,
	output reg         adapter_discharge_en_o,
	output reg         sys_discharge_en_o,
	// second control register fields
	output reg         diode_emu_dis_o,
	output reg         sink_dis_o,
	output reg         skip_trim_o,
	output reg         skip_autozero_o,
	output reg         force_reverse_o,
	output reg         audio_filter_o,
	output reg  [2:0]  sw_freq_sel_o,
	output reg         sys_amp_dis_o,
	output reg         bypass_en_o,
	output reg         fast_ref_en_o,
	output reg         stop_switching_o
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_DEB  = 2'h1;
	localparam [1:0] ST_HOLD = 2'h2;

	reg [15:0]      phase_offset_and_discharge_config;
	reg [15:0]      operation_options_config;
	reg [15:0]      fault_and_alert_timing_config;
	reg [5:0]       thr_field;
	reg [1:0]       state;
	reg [CNT_W-1:0] cnt;

	reg [1:0]       next_state;
	reg [CNT_W-1:0] next_cnt;
	reg [15:0]      next_rdata;
	reg             next_err;

	// reset code of the threshold field, cut from the full reset word
	localparam [15:0] THR_RESET_WORD = `RCATR_THR_RESET;
	localparam [5:0]  THR_RESET_CODE = THR_RESET_WORD[`RCATR_THR_MSB:`RCATR_THR_LSB];

	wire [5:0]       wr_thr   = wdata_i[`RCATR_THR_MSB:`RCATR_THR_LSB];
	wire [1:0]       deb_sel  = fault_and_alert_timing_config[`RCATR_DEB_MSB:`RCATR_DEB_LSB];
	wire [2:0]       dur_sel  = fault_and_alert_timing_config[`RCATR_DUR_MSB:`RCATR_DUR_LSB];
	// both sources share one debounce path
	wire             over_any = sys_over_thr_i | adapter_over_thr_i;
	// one extra bit so the increment never wraps before the compare
	wire [CNT_W:0]   cnt_inc  = cnt + 1'b1;

	// first control register fields
	wire [2:0]       fofs        = phase_offset_and_discharge_config[`RCATR_FOFS_MSB:`RCATR_FOFS_LSB];
	wire [2:0]       bofs        = phase_offset_and_discharge_config[`RCATR_BOFS_MSB:`RCATR_BOFS_LSB];
	wire [2:0]       rofs        = phase_offset_and_discharge_config[`RCATR_ROFS_MSB:`RCATR_ROFS_LSB];
	wire [1:0]       hss         = phase_offset_and_discharge_config[`RCATR_HSS_MSB:`RCATR_HSS_LSB];
	wire             vin_dis     = phase_offset_and_discharge_config[`RCATR_VIN_DIS_BIT];
	wire             adapter_dch = phase_offset_and_discharge_config[`RCATR_ADAPTER_DCH_BIT];
	wire             sys_dch     = phase_offset_and_discharge_config[`RCATR_SYS_DCH_BIT];

	// second control register fields
	wire             diode_dis   = operation_options_config[`RCATR_DIODE_BIT];
	wire             sink_off    = operation_options_config[`RCATR_SINK_BIT];
	wire             trim_skip   = operation_options_config[`RCATR_TRIM_BIT];
	wire             az_skip     = operation_options_config[`RCATR_AZ_BIT];
	wire             rev_force   = operation_options_config[`RCATR_REV_BIT];
	wire             audio_req   = operation_options_config[`RCATR_AUDIO_BIT];
	wire [2:0]       freq_sel    = operation_options_config[`RCATR_FREQ_MSB:`RCATR_FREQ_LSB];
	wire             amp_dis     = operation_options_config[`RCATR_AMP_BIT];
	wire             bypass_req  = operation_options_config[`RCATR_BYPASS_BIT];
	wire             fastref_req = operation_options_config[`RCATR_FASTREF_BIT];
	wire             stop_req    = operation_options_config[`RCATR_STOP_BIT];

	// least times round up; every figure is whole microseconds so cycles are exact
	function [CNT_W-1:0] us_to_cyc;
		input integer us;
		integer       prod;
		begin
			prod      = us * `RCATR_CLK_MHZ;
			us_to_cyc = prod[CNT_W-1:0];
		end
	endfunction

	// saturate rather than wrap, so an oversized request still lands on the top limit
	function [5:0] clamp_thr;
		input [5:0] code;
		begin
			clamp_thr = (code > `RCATR_THR_MAX) ? `RCATR_THR_MAX : code;
		end
	endfunction

	function cmd_mapped;
		input [7:0] code;
		begin
			cmd_mapped = (code == `RCATR_CMD_PHASE_CFG) || (code == `RCATR_CMD_OPT_CFG) ||
				(code == `RCATR_CMD_ALERT_CFG) || (code == `RCATR_CMD_SYS_THR);
		end
	endfunction

	function [CNT_W-1:0] deb_cycles;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    deb_cycles = us_to_cyc(`RCATR_DEB0_US);
				2'h1:    deb_cycles = us_to_cyc(`RCATR_DEB1_US);
				2'h2:    deb_cycles = us_to_cyc(`RCATR_DEB2_US);
				default: deb_cycles = us_to_cyc(`RCATR_DEB3_US);
			endcase
		end
	endfunction

	function [CNT_W-1:0] dur_cycles;
		input [2:0] sel;
		begin
			case (sel)
				3'h0:    dur_cycles = us_to_cyc(`RCATR_DUR0_US);
				3'h1:    dur_cycles = us_to_cyc(`RCATR_DUR1_US);
				3'h2:    dur_cycles = us_to_cyc(`RCATR_DUR2_US);
				3'h3:    dur_cycles = us_to_cyc(`RCATR_DUR3_US);
				3'h4:    dur_cycles = us_to_cyc(`RCATR_DUR4_US);
				3'h5:    dur_cycles = us_to_cyc(`RCATR_DUR5_US);
				3'h6:    dur_cycles = us_to_cyc(`RCATR_DUR6_US);
				default: dur_cycles = us_to_cyc(`RCATR_DUR7_US);
			endcase
		end
	endfunction

	// limits follow the timing register with no extra lag
	wire [CNT_W-1:0] deb_limit = deb_cycles(deb_sel);
	wire [CNT_W-1:0] dur_limit = dur_cycles(dur_sel);

	// register writes
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			phase_offset_and_discharge_config <= `RCATR_PHASE_RESET;
			operation_options_config          <= `RCATR_OPT_RESET;
			fault_and_alert_timing_config     <= `RCATR_ALERT_RESET;
			thr_field                         <= THR_RESET_CODE;
		end else if (wr_i) begin
			case (cmd_i)
				`RCATR_CMD_PHASE_CFG: phase_offset_and_discharge_config <= wdata_i;
				`RCATR_CMD_OPT_CFG:   operation_options_config <= wdata_i;
				`RCATR_CMD_ALERT_CFG: fault_and_alert_timing_config <= wdata_i;
				`RCATR_CMD_SYS_THR: begin
					thr_field <= clamp_thr(wr_thr);
				end
				default: ;
			endcase
		end
	end

	// read path; unmapped commands return zero with an error flag
	always @* begin
		next_err = ~cmd_mapped(cmd_i);
		case (cmd_i)
			`RCATR_CMD_PHASE_CFG: next_rdata = phase_offset_and_discharge_config;
			`RCATR_CMD_OPT_CFG:   next_rdata = operation_options_config;
			`RCATR_CMD_ALERT_CFG: next_rdata = fault_and_alert_timing_config;
			`RCATR_CMD_SYS_THR:   next_rdata = {2'h0, thr_field, 8'h00};
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rdata_o   <= 16'h0000;
			rvalid_o  <= 1'b0;
			cmd_err_o <= 1'b0;
		end else begin
			rvalid_o  <= rd_i;
			cmd_err_o <= (rd_i | wr_i) & next_err;
			if (rd_i) begin
				rdata_o <= next_rdata;
			end
		end
	end

	// alert: debounce the overcurrent level, then hold a minimum time
	always @* begin
		next_state = state;
		next_cnt   = cnt;
		case (state)
			ST_IDLE: begin
				next_cnt = {CNT_W{1'b0}};
				if (over_any) begin
					next_state = ST_DEB;
				end
			end
			ST_DEB: begin
				if (!over_any) begin
					next_state = ST_IDLE;
				end else if (cnt_inc >= deb_limit) begin
					next_state = ST_HOLD;
					next_cnt   = {CNT_W{1'b0}};
				end else begin
					next_cnt = cnt_inc[CNT_W-1:0];
				end
			end
			ST_HOLD: begin
				// a zero duration still gives one asserted cycle
				if (cnt_inc >= dur_limit && !over_any) begin
					next_state = ST_IDLE;
				end else if (cnt_inc < dur_limit) begin
					next_cnt = cnt_inc[CNT_W-1:0];
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state              <= ST_IDLE;
			cnt                <= {CNT_W{1'b0}};
			throttle_alert_n_o <= 1'b1;
		end else begin
			state              <= next_state;
			cnt                <= next_cnt;
			throttle_alert_n_o <= ~(next_state == ST_HOLD);
		end
	end

	// threshold and first control register outputs
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sys_thr_code_o         <= THR_RESET_CODE;
			forward_phase_ofs_o    <= 3'h0;
			boost_phase_ofs_o      <= 3'h0;
			rev_phase_ofs_o        <= 3'h0;
			hs_short_thr_o         <= 2'h0;
			vin_loop_dis_o         <= 1'b0;
			adapter_discharge_en_o <= 1'b0;
			sys_discharge_en_o     <= 1'b0;
		end else begin
			sys_thr_code_o         <= thr_field;
			forward_phase_ofs_o    <= fofs;
			boost_phase_ofs_o      <= bofs;
			rev_phase_ofs_o        <= rofs;
			hs_short_thr_o         <= hss;
			vin_loop_dis_o         <= vin_dis;
			adapter_discharge_en_o <= adapter_dch;
			sys_discharge_en_o     <= sys_dch;
		end
	end

	// second control register outputs, some gated by the operating state
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			diode_emu_dis_o    <= 1'b0;
			sink_dis_o         <= 1'b0;
			skip_trim_o        <= 1'b0;
			skip_autozero_o    <= 1'b0;
			force_reverse_o    <= 1'b0;
			audio_filter_o     <= 1'b0;
			sw_freq_sel_o      <= 3'h0;
			sys_amp_dis_o      <= 1'b0;
			bypass_en_o        <= 1'b0;
			fast_ref_en_o      <= 1'b0;
			stop_switching_o   <= 1'b0;
		end else begin
			diode_emu_dis_o    <= diode_dis;
			sink_dis_o         <= sink_off;
			// restart-only options are sampled while power is good, as the host is told to
			if (power_good_i) begin
				skip_trim_o     <= trim_skip;
				skip_autozero_o <= az_skip;
			end
			force_reverse_o    <= rev_force;
			audio_filter_o     <= audio_req & ~buck_boost_mode_i;
			sw_freq_sel_o      <= freq_sel;
			sys_amp_dis_o      <= amp_dis & forward_direction_i & ~adapter_source_i;
			bypass_en_o        <= bypass_req;
			fast_ref_en_o      <= fastref_req;
			stop_switching_o   <= stop_req & forward_direction_i;
		end
	end

endmodule // rcatr_regs
`default_nettype wire

/* src/rcatr_regs.vh */
// Purpose: constants for the regulator configuration and throttle register bank
// Assumes: word-wide register port, 25 MHz clock
// Notes: command codes double as register addresses
`ifndef RCATR_REGS_VH
`define RCATR_REGS_VH
`define RCATR_CMD_PHASE_CFG     8'h39
`define RCATR_CMD_OPT_CFG       8'h3c
`define RCATR_CMD_ALERT_CFG     8'h3d
`define RCATR_CMD_SYS_THR       8'h48
`define RCATR_THR_LSB           8
`define RCATR_THR_MSB           13
`define RCATR_THR_MAX           6'h32
`define RCATR_THR_RESET         16'h1000
`define RCATR_PHASE_RESET       16'h0000
`define RCATR_OPT_RESET         16'h0000
`define RCATR_ALERT_RESET       16'h0000
`define RCATR_DEB_LSB           9
`define RCATR_DEB_MSB           10
`define RCATR_DUR_LSB           6
`define RCATR_DUR_MSB           8
`define RCATR_CLK_MHZ           25
`define RCATR_DEB0_US           7
`define RCATR_DEB1_US           100
`define RCATR_DEB2_US           500
`define RCATR_DEB3_US           1000
`define RCATR_DUR0_US           10000
`define RCATR_DUR1_US           20000
`define RCATR_DUR2_US           15000
`define RCATR_DUR3_US           5000
`define RCATR_DUR4_US           1000
`define RCATR_DUR5_US           500
`define RCATR_DUR6_US           100
`define RCATR_DUR7_US           0
`define RCATR_FOFS_MSB          15
`define RCATR_FOFS_LSB          13
`define RCATR_BOFS_MSB          12
`define RCATR_BOFS_LSB          10
`define RCATR_ROFS_MSB          9
`define RCATR_ROFS_LSB          7
`define RCATR_HSS_MSB           6
`define RCATR_HSS_LSB           5
`define RCATR_VIN_DIS_BIT       2
`define RCATR_ADAPTER_DCH_BIT   1
`define RCATR_SYS_DCH_BIT       0
`define RCATR_DIODE_BIT         15
`define RCATR_SINK_BIT          14
`define RCATR_TRIM_BIT          13
`define RCATR_AZ_BIT            12
`define RCATR_REV_BIT           11
`define RCATR_AUDIO_BIT         10
`define RCATR_FREQ_MSB          9
`define RCATR_FREQ_LSB          7
`define RCATR_AMP_BIT           5
`define RCATR_BYPASS_BIT        4
`define RCATR_FASTREF_BIT       3
`define RCATR_STOP_BIT          2
`endif

/* dv/rcatr_regs_asserts.sv */
// Purpose: port checker for the register bank and throttle alert
// Assumes: one clock, asynchronous active-low reset
// Notes: alert timing figures are learnt from writes to code 0x3d
`timescale 1ns/1ps
`default_nettype none
module rcatr_regs_asserts (
	// clock and reset
	input wire        clk_i,
	input wire        reset_n_i,
	// register port
	input wire        wr_i,
	input wire        rd_i,
	input wire [7:0]  cmd_i,
	input wire [15:0] wdata_i,
	input wire [15:0] rdata_o,
	input wire        rvalid_o,
	input wire        cmd_err_o,
	// operating state and alert
	input wire        forward_direction_i,
	input wire        sys_over_thr_i,
	input wire        adapter_over_thr_i,
	input wire [5:0]  sys_thr_code_o,
	input wire        throttle_alert_n_o,
	input wire        stop_switching_o
);
	localparam int DEB [4] = '{175, 2500, 12500, 25000};
	localparam int HOLD [8] = '{250000, 500000, 375000, 125000, 25000, 12500, 2500, 1};
	reg  [1:0]  deb;
	reg  [2:0]  dur;
	reg  [15:0] over_cnt;
	reg  [19:0] low_cnt;
	wire        over   = sys_over_thr_i | adapter_over_thr_i;
	wire        mapped = cmd_i == 8'h39 || cmd_i == 8'h3c || cmd_i == 8'h3d || cmd_i == 8'h48;
	wire [5:0]  thr_in = wdata_i[13:8] > 6'h32 ? 6'h32 : wdata_i[13:8];
	always @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			deb <= 2'h0;
			dur <= 3'h0;
			over_cnt <= 16'h0;
			low_cnt <= 20'h0;
		end else begin
			if (wr_i && cmd_i == 8'h3d) begin
				deb <= wdata_i[10:9];
				dur <= wdata_i[8:6];
			end
			// saturates so long debounces cannot wrap
			over_cnt <= !over ? 16'h0 : (&over_cnt ? over_cnt : over_cnt + 16'h1);
			low_cnt <= throttle_alert_n_o ? 20'h0 : low_cnt + 20'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_thr_read;
		rd_i && cmd_i == 8'h48;
	endsequence
	sequence s_thr_write;
		wr_i && cmd_i == 8'h48;
	endsequence
	a_read_answer: assert property (rd_i |=> rvalid_o) else $error("read not answered");
	a_read_hold: assert property (!rd_i |=> $stable(rdata_o)) else $error("read data moved");
	a_thr_format: assert property (s_thr_read |=> rdata_o[15:14] == 2'h0 &&
		rdata_o[7:0] == 8'h00 && rdata_o[13:8] <= 6'h32) else $error("threshold read badly formed");
	a_thr_store: assert property (s_thr_write |-> ##2 sys_thr_code_o == $past(thr_in, 2))
		else $error("threshold not stored clamped");
	a_cmd_error: assert property ((wr_i || rd_i) |=> cmd_err_o == !$past(mapped)) else $error("code error wrong");
	a_unmapped_zero: assert property (rd_i && !mapped |=> rdata_o == 16'h0) else $error("unmapped read not zero");
	a_alert_debounce: assert property ($fell(throttle_alert_n_o) |-> over_cnt >= DEB[deb])
		else $error("alert before debounce");
	a_alert_hold: assert property ($rose(throttle_alert_n_o) |-> low_cnt >= HOLD[dur] && !$past(over))
		else $error("alert released early");
	a_stop_forward: assert property (!forward_direction_i |=> !stop_switching_o) else $error("stop outside forward");
endmodule // rcatr_regs_asserts
bind rcatr_regs rcatr_regs_asserts i_chk (.clk_i, .reset_n_i, .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .rvalid_o,
	.cmd_err_o, .forward_direction_i, .sys_over_thr_i, .adapter_over_thr_i, .sys_thr_code_o, .throttle_alert_n_o,
	.stop_switching_o);
`default_nettype wire

/* dv/rcatr_host.sv */
// Purpose: host model issuing word strobes on the register port
// Assumes: requests change at the falling edge
// Notes: the read waits a bounded time for its answer
`timescale 1ns/1ps
`default_nettype none
module rcatr_host (
	// clock
	input  wire         clk_i,
	// register port
	output logic        wr_o,
	output logic        rd_o,
	output logic [7:0]  cmd_o,
	output logic [15:0] wdata_o,
	input  wire  [15:0] rdata_i,
	input  wire         rvalid_i,
	input  wire         cmd_err_i
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		cmd_o = 8'h00;
		wdata_o = 16'h0000;
	end
	task automatic write(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk_i);
		cmd_o = c;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge clk_i);
		wr_o = 1'b0;
		// released data shows no stale word
		wdata_o = ~d;
	endtask
	task automatic read(input logic [7:0] c, output logic [15:0] d, output logic e, output logic ok);
		@(negedge clk_i);
		cmd_o = c;
		rd_o = 1'b1;
		@(negedge clk_i);
		rd_o = 1'b0;
		ok = 1'b0;
		for (int n = 0; n < 4 && !ok; n++) begin
			if (n > 0) @(negedge clk_i);
			ok = rvalid_i === 1'b1 || cmd_err_i === 1'b1;
		end
		d = rdata_i;
		e = cmd_err_i;
	endtask
endmodule // rcatr_host
`default_nettype wire

/* dv/rcatr_regs_tb.sv */
// Purpose: self-checking bench for the register bank
// Assumes: inputs change at the falling edge
// Notes: long alert counts use only the shorter codes
`timescale 1ns/1ps
`default_nettype none
module rcatr_regs_tb;
	logic        clk_i = 1'b0, reset_n_i = 1'b0, wr_i, rd_i, rvalid_o, cmd_err_o, throttle_alert_n_o, err, ok;
	logic [7:0]  cmd_i;
	logic [15:0] wdata_i, rdata_o, rd_val;
	logic [5:0]  sys_thr_code_o;
	logic        power_good_i = 1'b1, forward_direction_i = 1'b1, adapter_source_i = 1'b0, buck_boost_mode_i = 1'b0;
	logic        sys_over_thr_i = 1'b0, adapter_over_thr_i = 1'b0;
	logic        vin_loop_dis_o, adapter_discharge_en_o, sys_discharge_en_o;
	logic [2:0]  forward_phase_ofs_o, boost_phase_ofs_o, rev_phase_ofs_o, sw_freq_sel_o;
	logic [1:0]  hs_short_thr_o;
	logic        diode_emu_dis_o, sink_dis_o, skip_trim_o, skip_autozero_o, force_reverse_o, audio_filter_o;
	logic        sys_amp_dis_o, bypass_en_o, fast_ref_en_o, stop_switching_o;
	logic [15:0] thr_w [5] = '{16'hffff, 16'h31ff, 16'h3300, 16'hc0a5, 16'h0100};
	logic [15:0] thr_e [5] = '{16'h3200, 16'h3100, 16'h3200, 16'h0000, 16'h0100};
	int          bad_count = 0, checks = 0, n;
	int          deb_c [4] = '{175, 2500, 12500, 25000};
	int          hold_c [4] = '{25000, 12500, 2500, 1};
	always #20 clk_i = ~clk_i;
	rcatr_regs i_dut (.clk_i, .reset_n_i, .wr_i, .rd_i, .cmd_i, .wdata_i, .rdata_o, .rvalid_o, .cmd_err_o,
		.power_good_i, .forward_direction_i, .adapter_source_i, .buck_boost_mode_i, .sys_over_thr_i,
		.adapter_over_thr_i, .sys_thr_code_o, .throttle_alert_n_o, .forward_phase_ofs_o, .boost_phase_ofs_o,
		.rev_phase_ofs_o, .hs_short_thr_o, .vin_loop_dis_o, .adapter_discharge_en_o, .sys_discharge_en_o,
		.diode_emu_dis_o, .sink_dis_o, .skip_trim_o,
		.skip_autozero_o, .force_reverse_o, .audio_filter_o, .sw_freq_sel_o, .sys_amp_dis_o, .bypass_en_o,
		.fast_ref_en_o, .stop_switching_o);
	rcatr_host i_host (.clk_i, .wr_o(wr_i), .rd_o(rd_i), .cmd_o(cmd_i), .wdata_o(wdata_i), .rdata_i(rdata_o),
		.rvalid_i(rvalid_o), .cmd_err_i(cmd_err_o));
	task automatic chk(input string what, input logic [19:0] seen, input logic [19:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdchk(input logic [7:0] c, input logic [15:0] exp);
		i_host.read(c, rd_val, err, ok);
		chk("read answer", ok, 1'b1);
		chk("read data", rd_val, exp);
		chk("read error", err, !(c == 8'h39 || c == 8'h3c || c == 8'h3d || c == 8'h48));
	endtask
	task automatic test_done;
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_alert(input logic lvl, input int lim, output int cnt);
		for (cnt = 0; throttle_alert_n_o !== lvl; cnt++) begin
			if (cnt >= lim) begin
				chk("alert wait", 1'b0, 1'b1);
				test_done();
			end
			@(negedge clk_i);
		end
	endtask
	initial begin
		repeat (3) @(negedge clk_i);
		reset_n_i = 1'b1;
		chk("thr code", sys_thr_code_o, 6'h10);
		rdchk(8'h48, 16'h1000);
		rdchk(8'h3c, 16'h0000);
		for (int i = 0; i < 5; i++) begin
			i_host.write(8'h48, thr_w[i]);
			rdchk(8'h48, thr_e[i]);
			chk("thr code", sys_thr_code_o, thr_e[i][13:8]);
		end
		i_host.write(8'h40, 16'hffff);
		chk("write error", cmd_err_o, 1'b1);
		rdchk(8'h40, 16'h0000);
		rdchk(8'h48, 16'h0100);
		for (int k = 0; k < 8; k++) begin
			i_host.write(8'h39, {k[2:0], k[2:0], k[2:0], k[1:0], 2'h0, k[2:0]});
			i_host.write(8'h3c, {k[0], k[1], k[2], k[0], k[1], k[2], k[2:0], 1'b0, k[0], k[1], k[2], k[0], 2'h0});
			@(negedge clk_i);
			chk("first fields", {
				forward_phase_ofs_o, boost_phase_ofs_o, rev_phase_ofs_o, hs_short_thr_o, vin_loop_dis_o,
				adapter_discharge_en_o, sys_discharge_en_o}, {k[2:0], k[2:0], k[2:0], k[1:0], k[2:0]});
			chk("second fields", {
				diode_emu_dis_o, sink_dis_o, skip_trim_o, skip_autozero_o, force_reverse_o, audio_filter_o,
				sw_freq_sel_o, sys_amp_dis_o, bypass_en_o, fast_ref_en_o, stop_switching_o},
				{k[0], k[1], k[2], k[0], k[1], k[2], k[2:0], k[0], k[1], k[2], k[0]});
		end
		forward_direction_i = 1'b0;
		buck_boost_mode_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("gated off", {sys_amp_dis_o, audio_filter_o, stop_switching_o}, 3'h0);
		forward_direction_i = 1'b1;
		adapter_source_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("adapter gate", {sys_amp_dis_o, stop_switching_o}, 2'h1);
		power_good_i = 1'b0;
		i_host.write(8'h3c, 16'h0000);
		@(negedge clk_i);
		chk("skip held", {skip_trim_o, skip_autozero_o, diode_emu_dis_o}, 3'h6);
		power_good_i = 1'b1;
		repeat (2) @(negedge clk_i);
		chk("skip tracks", {skip_trim_o, skip_autozero_o}, 2'h0);
		i_host.write(8'h3d, 16'h01c0);
		sys_over_thr_i = 1'b1;
		repeat (100) @(negedge clk_i);
		sys_over_thr_i = 1'b0;
		repeat (100) @(negedge clk_i);
		chk("short over", throttle_alert_n_o, 1'b1);
		for (int d = 0; d < 4; d++) begin
			i_host.write(8'h3d, {5'h0, d[1:0], 3'h7, 6'h0});
			{adapter_over_thr_i, sys_over_thr_i} = d[0] ? 2'h2 : 2'h1;
			wait_alert(1'b0, 26000, n);
			chk("debounce", n >= deb_c[d] && n <= deb_c[d] + 3, 1'b1);
			repeat (20) @(negedge clk_i);
			chk("held while over", throttle_alert_n_o, 1'b0);
			{adapter_over_thr_i, sys_over_thr_i} = 2'h0;
			wait_alert(1'b1, 10, n);
		end
		for (int h = 0; h < 4; h++) begin
			i_host.write(8'h3d, {7'h0, 1'b1, h[1:0], 6'h0});
			sys_over_thr_i = 1'b1;
			wait_alert(1'b0, 200, n);
			sys_over_thr_i = 1'b0;
			wait_alert(1'b1, 26000, n);
			chk("hold", n >= hold_c[h] - 1 && n <= hold_c[h] + 4, 1'b1);
		end
		reset_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		reset_n_i = 1'b1;
		rdchk(8'h48, 16'h1000);
		test_done();
	end
endmodule // rcatr_regs_tb
`default_nettype wire
